//--- hw/scm_pkg.sv
// constants and types shared by the socket pin multiplexer
package scm_pkg;

	typedef enum logic {
		SCM_MODE_16,
		SCM_MODE_CB
	} scm_mode_t;

	// address pins with a dedicated cardbus function
	localparam int A_IRDY = 15;
	localparam int A_PERR = 14;
	localparam int A_PAR = 13;
	localparam int A_CBE2 = 12;
	localparam int A_CBE1 = 8;

	// data pins with no cardbus function
	localparam int D_RSV_HI = 14;
	localparam int D_RSV_LO = 2;

	// control pin slots in the ctl vectors
	localparam int CTL_OE = 0;
	localparam int CTL_WE = 1;
	localparam int CTL_CE1 = 2;
	localparam int CTL_CE2 = 3;

	// address/data lanes carried by the control pins in cardbus mode
	localparam logic [4:0] CAD_ON_OE = 5'h0b;
	localparam logic [4:0] CAD_ON_CE2 = 5'h0a;

	// pins that carry an address/data lane in cardbus mode
	localparam logic [15:0] A_CAD_MASK = 16'h0eff;
	localparam logic [15:0] D_CAD_MASK = 16'hbffb;

	// lane carried by each address pin, index is the pin bit
	localparam logic [4:0] A_CAD_IDX [16] = '{
		5'h1a, 5'h19, 5'h18, 5'h17, 5'h16, 5'h15, 5'h14, 5'h12,
		5'h00, 5'h0e, 5'h09, 5'h0c, 5'h00, 5'h00, 5'h00, 5'h00
	};

	// lane carried by each data pin, index is the pin bit
	localparam logic [4:0] D_CAD_IDX [16] = '{
		5'h1b, 5'h1d, 5'h00, 5'h00, 5'h01, 5'h03, 5'h05, 5'h07,
		5'h1c, 5'h1e, 5'h1f, 5'h02, 5'h04, 5'h06, 5'h00, 5'h08
	};

	localparam logic [15:0] PIN_RST = 16'h0000;
	localparam logic [3:0] CTL_RST = 4'h0;

endpackage

//--- hw/scm_pin_if.sv
// cardbus signals and their socket pin images, between top and lane mapper
interface scm_pin_if;
	logic [31:0] cad_out;
	logic [31:0] cad_oe;
	logic [31:0] cad_in;
	logic [2:0] cbe_n_out;
	logic [2:0] cbe_oe;
	logic [2:0] cbe_n_in;
	logic irdy_n_out;
	logic irdy_oe;
	logic irdy_n_in;
	logic perr_n_out;
	logic perr_oe;
	logic perr_n_in;
	logic par_out;
	logic par_oe;
	logic par_in;
	logic gnt_n;
	logic [15:0] a_out;
	logic [15:0] a_oe;
	logic [15:0] a_in;
	logic [15:0] d_out;
	logic [15:0] d_oe;
	logic [15:0] d_in;
	logic [3:0] c_out;
	logic [3:0] c_oe;
	logic [3:0] c_in;

	modport mapper (
		input cad_out, cad_oe, cbe_n_out, cbe_oe, irdy_n_out, irdy_oe,
		input perr_n_out, perr_oe, par_out, par_oe, gnt_n, a_in, d_in, c_in,
		output cad_in, cbe_n_in, irdy_n_in, perr_n_in, par_in,
		output a_out, a_oe, d_out, d_oe, c_out, c_oe
	);

	modport top (
		output cad_out, cad_oe, cbe_n_out, cbe_oe, irdy_n_out, irdy_oe,
		output perr_n_out, perr_oe, par_out, par_oe, gnt_n, a_in, d_in, c_in,
		input cad_in, cbe_n_in, irdy_n_in, perr_n_in, par_in,
		input a_out, a_oe, d_out, d_oe, c_out, c_oe
	);
endinterface

//--- hw/scm_cb_map.sv
// places cardbus signals onto the shared socket pins and gathers them back
module scm_cb_map (
	scm_pin_if.mapper pins
);

	always_comb begin
		pins.a_out = scm_pkg::PIN_RST;
		pins.a_oe = scm_pkg::PIN_RST;
		pins.d_out = scm_pkg::PIN_RST;
		pins.d_oe = scm_pkg::PIN_RST;
		pins.cad_in = 32'h0000_0000;
		for (int i = 0; i < 16; i++) begin
			if (scm_pkg::A_CAD_MASK[i]) begin
				pins.a_out[i] = pins.cad_out[scm_pkg::A_CAD_IDX[i]];
				pins.a_oe[i] = pins.cad_oe[scm_pkg::A_CAD_IDX[i]];
				pins.cad_in[scm_pkg::A_CAD_IDX[i]] = pins.a_in[i];
			end
			if (scm_pkg::D_CAD_MASK[i]) begin
				pins.d_out[i] = pins.cad_out[scm_pkg::D_CAD_IDX[i]];
				pins.d_oe[i] = pins.cad_oe[scm_pkg::D_CAD_IDX[i]];
				pins.cad_in[scm_pkg::D_CAD_IDX[i]] = pins.d_in[i];
			end
		end
		// reserved data pins stay released in cardbus mode
		pins.d_out[scm_pkg::D_RSV_HI] = 1'b0;
		pins.d_oe[scm_pkg::D_RSV_HI] = 1'b0;
		pins.d_out[scm_pkg::D_RSV_LO] = 1'b0;
		pins.d_oe[scm_pkg::D_RSV_LO] = 1'b0;
		pins.a_out[scm_pkg::A_IRDY] = pins.irdy_n_out;
		pins.a_oe[scm_pkg::A_IRDY] = pins.irdy_oe;
		pins.a_out[scm_pkg::A_PERR] = pins.perr_n_out;
		pins.a_oe[scm_pkg::A_PERR] = pins.perr_oe;
		pins.a_out[scm_pkg::A_PAR] = pins.par_out;
		pins.a_oe[scm_pkg::A_PAR] = pins.par_oe;
		pins.a_out[scm_pkg::A_CBE2] = pins.cbe_n_out[2];
		pins.a_oe[scm_pkg::A_CBE2] = pins.cbe_oe[2];
		pins.a_out[scm_pkg::A_CBE1] = pins.cbe_n_out[1];
		pins.a_oe[scm_pkg::A_CBE1] = pins.cbe_oe[1];
		pins.c_out = scm_pkg::CTL_RST;
		pins.c_oe = scm_pkg::CTL_RST;
		pins.c_out[scm_pkg::CTL_OE] = pins.cad_out[scm_pkg::CAD_ON_OE];
		pins.c_oe[scm_pkg::CTL_OE] = pins.cad_oe[scm_pkg::CAD_ON_OE];
		pins.c_out[scm_pkg::CTL_WE] = pins.gnt_n;
		pins.c_oe[scm_pkg::CTL_WE] = 1'b1;
		pins.c_out[scm_pkg::CTL_CE1] = pins.cbe_n_out[0];
		pins.c_oe[scm_pkg::CTL_CE1] = pins.cbe_oe[0];
		pins.c_out[scm_pkg::CTL_CE2] = pins.cad_out[scm_pkg::CAD_ON_CE2];
		pins.c_oe[scm_pkg::CTL_CE2] = pins.cad_oe[scm_pkg::CAD_ON_CE2];
		pins.cad_in[scm_pkg::CAD_ON_OE] = pins.c_in[scm_pkg::CTL_OE];
		pins.cad_in[scm_pkg::CAD_ON_CE2] = pins.c_in[scm_pkg::CTL_CE2];
		pins.cbe_n_in = {pins.a_in[scm_pkg::A_CBE2], pins.a_in[scm_pkg::A_CBE1],
			pins.c_in[scm_pkg::CTL_CE1]};
		pins.irdy_n_in = pins.a_in[scm_pkg::A_IRDY];
		pins.perr_n_in = pins.a_in[scm_pkg::A_PERR];
		pins.par_in = pins.a_in[scm_pkg::A_PAR];
	end

endmodule

//--- hw/scm_top.sv
// socket address, data and strobe pin multiplexer for 16-bit and cardbus cards
module scm_top (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic mode_cb_i,
	input wire logic drive_en_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic mem_rd_i,
	input wire logic mem_wr_i,
	input wire logic word_i,
	input wire logic card_8bit_i,
	input wire logic [31:0] cb_ad_i,
	input wire logic [31:0] cb_ad_oe_i,
	input wire logic [2:0] cb_cbe_n_i,
	input wire logic [2:0] cb_cbe_oe_i,
	input wire logic cb_irdy_n_i,
	input wire logic cb_irdy_oe_i,
	input wire logic cb_perr_n_i,
	input wire logic cb_perr_oe_i,
	input wire logic cb_par_i,
	input wire logic cb_par_oe_i,
	input wire logic cb_gnt_n_i,
	input wire logic [15:0] sock_a_i,
	input wire logic [15:0] sock_d_i,
	input wire logic sock_oe_n_i,
	input wire logic sock_we_n_i,
	input wire logic sock_even_byte_enable_n_i,
	input wire logic sock_odd_byte_enable_n_i,
	output logic [15:0] sock_a_o,
	output logic [15:0] sock_a_oe_o,
	output logic [15:0] sock_d_o,
	output logic [15:0] sock_d_oe_o,
	output logic sock_oe_n_o,
	output logic sock_oe_n_oe_o,
	output logic sock_we_n_o,
	output logic sock_we_n_oe_o,
	output logic sock_even_byte_enable_n_o,
	output logic sock_even_byte_enable_n_oe_o,
	output logic sock_odd_byte_enable_n_o,
	output logic sock_odd_byte_enable_n_oe_o,
	output logic [15:0] rdata_o,
	output logic [31:0] cb_ad_o,
	output logic [2:0] cb_cbe_n_o,
	output logic cb_irdy_n_o,
	output logic cb_perr_n_o,
	output logic cb_par_o
);

	scm_pin_if pins ();

	scm_pkg::scm_mode_t mode;
	logic cyc;
	logic rd_act;
	logic wr_act;
	logic even_n;
	logic odd_n;

	logic [15:0] a_out;
	logic [15:0] a_oe;
	logic [15:0] d_out;
	logic [15:0] d_oe;
	logic [3:0] c_out;
	logic [3:0] c_oe;
	logic [15:0] rdata;
	logic [31:0] cad_in;
	logic [2:0] cbe_in;
	logic irdy_in;
	logic perr_in;
	logic par_in;

	logic [15:0] next_a_out;
	logic [15:0] next_a_oe;
	logic [15:0] next_d_out;
	logic [15:0] next_d_oe;
	logic [3:0] next_c_out;
	logic [3:0] next_c_oe;
	logic [15:0] next_rdata;
	logic [31:0] next_cad_in;
	logic [2:0] next_cbe_in;
	logic next_irdy_in;
	logic next_perr_in;
	logic next_par_in;

	assign pins.cad_out = cb_ad_i;
	assign pins.cad_oe = cb_ad_oe_i;
	assign pins.cbe_n_out = cb_cbe_n_i;
	assign pins.cbe_oe = cb_cbe_oe_i;
	assign pins.irdy_n_out = cb_irdy_n_i;
	assign pins.irdy_oe = cb_irdy_oe_i;
	assign pins.perr_n_out = cb_perr_n_i;
	assign pins.perr_oe = cb_perr_oe_i;
	assign pins.par_out = cb_par_i;
	assign pins.par_oe = cb_par_oe_i;
	assign pins.gnt_n = cb_gnt_n_i;
	assign pins.a_in = sock_a_i;
	assign pins.d_in = sock_d_i;
	assign pins.c_in = {sock_odd_byte_enable_n_i, sock_even_byte_enable_n_i,
		sock_we_n_i, sock_oe_n_i};

	scm_cb_map u_map (
		.pins(pins)
	);

	assign mode = mode_cb_i ? scm_pkg::SCM_MODE_CB : scm_pkg::SCM_MODE_16;

	// a read wins when both strobes are requested at once
	assign rd_act = mem_rd_i;
	assign wr_act = mem_wr_i & ~mem_rd_i;
	assign cyc = rd_act | wr_act;

	// byte lane strobes for 16-bit cards
	always_comb begin
		if (card_8bit_i) begin
			even_n = ~cyc;
			odd_n = 1'b1;
		end else if (word_i) begin
			even_n = ~cyc;
			odd_n = ~cyc;
		end else begin
			even_n = ~(cyc & ~addr_i[0]);
			odd_n = ~(cyc & addr_i[0]);
		end
	end

	always_comb begin
		next_a_out = scm_pkg::PIN_RST;
		next_a_oe = scm_pkg::PIN_RST;
		next_d_out = scm_pkg::PIN_RST;
		next_d_oe = scm_pkg::PIN_RST;
		next_c_out = scm_pkg::CTL_RST;
		next_c_oe = scm_pkg::CTL_RST;
		next_rdata = rdata;
		next_cad_in = cad_in;
		next_cbe_in = cbe_in;
		next_irdy_in = irdy_in;
		next_perr_in = perr_in;
		next_par_in = par_in;
		unique case (mode)
			scm_pkg::SCM_MODE_16: begin
				if (drive_en_i) begin
					next_a_out = addr_i;
					next_a_oe = 16'hffff;
					next_d_out = wdata_i;
					next_d_oe = {16{wr_act}};
					next_c_out[scm_pkg::CTL_OE] = ~rd_act;
					next_c_out[scm_pkg::CTL_WE] = ~wr_act;
					next_c_out[scm_pkg::CTL_CE1] = even_n;
					next_c_out[scm_pkg::CTL_CE2] = odd_n;
					next_c_oe = 4'hf;
				end
				next_rdata = sock_d_i;
			end
			scm_pkg::SCM_MODE_CB: begin
				// cardbus pins follow the lane mapper; 16-bit read data holds its last value
				next_a_out = pins.a_out;
				next_a_oe = pins.a_oe;
				next_d_out = pins.d_out;
				next_d_oe = pins.d_oe;
				next_c_out = pins.c_out;
				next_c_oe = pins.c_oe;
				next_cad_in = pins.cad_in;
				next_cbe_in = pins.cbe_n_in;
				next_irdy_in = pins.irdy_n_in;
				next_perr_in = pins.perr_n_in;
				next_par_in = pins.par_in;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			a_out <= scm_pkg::PIN_RST;
			a_oe <= scm_pkg::PIN_RST;
			d_out <= scm_pkg::PIN_RST;
			d_oe <= scm_pkg::PIN_RST;
			c_out <= scm_pkg::CTL_RST;
			c_oe <= scm_pkg::CTL_RST;
			rdata <= 16'h0000;
			cad_in <= 32'h0000_0000;
			cbe_in <= 3'h7;
			irdy_in <= 1'b1;
			perr_in <= 1'b1;
			par_in <= 1'b0;
		end else begin
			a_out <= next_a_out;
			a_oe <= next_a_oe;
			d_out <= next_d_out;
			d_oe <= next_d_oe;
			c_out <= next_c_out;
			c_oe <= next_c_oe;
			rdata <= next_rdata;
			cad_in <= next_cad_in;
			cbe_in <= next_cbe_in;
			irdy_in <= next_irdy_in;
			perr_in <= next_perr_in;
			par_in <= next_par_in;
		end
	end

	assign sock_a_o = a_out;
	assign sock_a_oe_o = a_oe;
	assign sock_d_o = d_out;
	assign sock_d_oe_o = d_oe;
	assign sock_oe_n_o = c_out[scm_pkg::CTL_OE];
	assign sock_oe_n_oe_o = c_oe[scm_pkg::CTL_OE];
	assign sock_we_n_o = c_out[scm_pkg::CTL_WE];
	assign sock_we_n_oe_o = c_oe[scm_pkg::CTL_WE];
	assign sock_even_byte_enable_n_o = c_out[scm_pkg::CTL_CE1];
	assign sock_even_byte_enable_n_oe_o = c_oe[scm_pkg::CTL_CE1];
	assign sock_odd_byte_enable_n_o = c_out[scm_pkg::CTL_CE2];
	assign sock_odd_byte_enable_n_oe_o = c_oe[scm_pkg::CTL_CE2];
	assign rdata_o = rdata;
	assign cb_ad_o = cad_in;
	assign cb_cbe_n_o = cbe_in;
	assign cb_irdy_n_o = irdy_in;
	assign cb_perr_n_o = perr_in;
	assign cb_par_o = par_in;

endmodule

//--- testbench/scm_top_assertions.sv
// concurrent checks on the socket pin multiplexer ports
module scm_top_assertions (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic mode_cb_i,
	input wire logic drive_en_i,
	input wire logic mem_rd_i,
	input wire logic mem_wr_i,
	input wire logic card_8bit_i,
	input wire logic [31:0] cb_ad_i,
	input wire logic cb_irdy_n_i,
	input wire logic cb_gnt_n_i,
	input wire logic [15:0] sock_a_o,
	input wire logic [15:0] sock_a_oe_o,
	input wire logic [15:0] sock_d_o,
	input wire logic [15:0] sock_d_oe_o,
	input wire logic sock_oe_n_o,
	input wire logic sock_we_n_o,
	input wire logic sock_we_n_oe_o,
	input wire logic sock_even_byte_enable_n_o
);
	logic [31:0] ad_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	always_ff @(posedge clk_i) begin
		ad_q <= cb_ad_i;
	end
	a_irdy_pin_map: assert property (mode_cb_i |=> sock_a_o[15] == $past(cb_irdy_n_i))
		else $error("irdy pin wrong");
	a_mid_addr_lanes: assert property (mode_cb_i |=> sock_a_o[11:9] == {ad_q[12], ad_q[9], ad_q[14]})
		else $error("address pins 11..9 lanes wrong");
	a_low_addr_lanes: assert property (mode_cb_i |=> sock_a_o[7:0] ==
		{ad_q[18], ad_q[20], ad_q[21], ad_q[22], ad_q[23], ad_q[24], ad_q[25], ad_q[26]})
		else $error("address pins 7..0 lanes wrong");
	a_reserved_released: assert property (mode_cb_i |=> !sock_d_oe_o[14] && !sock_d_oe_o[2])
		else $error("reserved data pin driven");
	a_read_strobe: assert property (!mode_cb_i && drive_en_i |=> sock_oe_n_o == !$past(mem_rd_i))
		else $error("output strobe wrong");
	a_write_strobe: assert property (!mode_cb_i && drive_en_i && !mem_rd_i
		|=> sock_we_n_o == !$past(mem_wr_i))
		else $error("write strobe wrong");
	a_grant_pin: assert property (mode_cb_i |=> sock_we_n_oe_o && sock_we_n_o == $past(cb_gnt_n_i))
		else $error("grant pin wrong");
	a_narrow_even: assert property (!mode_cb_i && drive_en_i && card_8bit_i && mem_wr_i
		|=> !sock_even_byte_enable_n_o)
		else $error("even strobe idle on narrow card");
	a_all_released: assert property (!mode_cb_i && !drive_en_i
		|=> sock_a_oe_o == 16'h0000 && sock_d_oe_o == 16'h0000)
		else $error("pins driven while released");
endmodule

bind scm_top scm_top_assertions chk (.*);

//--- testbench/scm_card_model.sv
// behavioural inserted card on the data pins, resolving the shared wire
module scm_card_model (
	input wire logic clk_i,
	input wire logic cb,
	input wire logic oe_n,
	input wire logic [15:0] d_o,
	input wire logic [15:0] d_oe,
	input wire logic [15:0] card_data,
	output logic [15:0] d_lvl
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] churn = 16'h0000;
	// a floating wire shows a changing pattern, never the last value
	always @(posedge clk_i) churn <= churn + 16'h3b5d;
	always_comb d_lvl = (d_oe & d_o) | (~d_oe & ((cb || !oe_n) ? card_data : churn));
endmodule

//--- testbench/scm_top_bench.sv
// bench for the socket pin multiplexer with a card model on the data pins
module scm_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic mode_cb_i = 1'b0, drive_en_i = 1'b0, mem_rd_i = 1'b0, mem_wr_i = 1'b0;
	logic word_i = 1'b0, card_8bit_i = 1'b0, cb_gnt_n_i = 1'b1;
	logic cb_irdy_n_i = 1'b1, cb_perr_n_i = 1'b1, cb_par_i = 1'b0;
	logic cb_irdy_oe_i = 1'b0, cb_perr_oe_i = 1'b0, cb_par_oe_i = 1'b0;
	logic [2:0] cb_cbe_n_i = 3'h7, cb_cbe_oe_i = 3'h0;
	logic [15:0] addr_i = 16'h0000, wdata_i = 16'h0000, card_data = 16'h0000;
	logic [31:0] cb_ad_i = 32'h0, cb_ad_oe_i = 32'h0, cb_ad_o;
	logic [15:0] sock_a_i, sock_d_i, sock_a_o, sock_a_oe_o, sock_d_o, sock_d_oe_o, rdata_o;
	logic sock_oe_n_i, sock_we_n_i, sock_even_byte_enable_n_i, sock_odd_byte_enable_n_i;
	logic sock_oe_n_o, sock_oe_n_oe_o, sock_we_n_o, sock_we_n_oe_o;
	logic sock_even_byte_enable_n_o, sock_even_byte_enable_n_oe_o;
	logic sock_odd_byte_enable_n_o, sock_odd_byte_enable_n_oe_o;
	logic [2:0] cb_cbe_n_o;
	logic cb_irdy_n_o, cb_perr_n_o, cb_par_o;
	int miscompares = 0;
	int checked = 0;
	assign sock_a_i = sock_a_o;
	assign sock_oe_n_i = sock_oe_n_o;
	assign sock_we_n_i = sock_we_n_o;
	assign sock_even_byte_enable_n_i = sock_even_byte_enable_n_o;
	assign sock_odd_byte_enable_n_i = sock_odd_byte_enable_n_o;
	scm_top uut (.*);
	scm_card_model card (.clk_i(clk_i), .cb(mode_cb_i), .oe_n(sock_oe_n_o), .d_o(sock_d_o),
		.d_oe(sock_d_oe_o), .card_data(card_data), .d_lvl(sock_d_i));
	always #10 clk_i = ~clk_i;
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic complete_run;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic t_read;
		drive_en_i = 1'b1;
		addr_i = 16'h8a5c;
		mem_rd_i = 1'b1;
		card_data = 16'h3c96;
		step(1);
		check(sock_a_o, 16'h8a5c);
		check(sock_oe_n_o, 1'b0);
		check(sock_we_n_o, 1'b1);
		step(1);
		check(rdata_o, 16'h3c96);
		mem_rd_i = 1'b0;
		step(1);
		check(sock_oe_n_o, 1'b1);
	endtask
	task automatic t_write;
		mem_wr_i = 1'b1;
		wdata_i = 16'h5a3c;
		for (int k = 0; k < 8; k++) begin
			{word_i, card_8bit_i, addr_i[0]} = k[2:0];
			step(1);
			check(sock_we_n_o, 1'b0);
			check(sock_d_o, 16'h5a3c);
			check(sock_even_byte_enable_n_o, !(card_8bit_i | word_i | !addr_i[0]));
			check(sock_odd_byte_enable_n_o, !(!card_8bit_i & (word_i | addr_i[0])));
			check({sock_oe_n_oe_o, sock_we_n_oe_o, sock_even_byte_enable_n_oe_o,
				sock_odd_byte_enable_n_oe_o}, 4'hf);
			check(sock_d_oe_o, 16'hffff);
		end
		drive_en_i = 1'b0;
		step(1);
		check({sock_a_oe_o, sock_d_oe_o}, 32'h0);
		mem_wr_i = 1'b0;
	endtask
	task automatic t_cardbus;
		logic [31:0] v;
		mode_cb_i = 1'b1;
		{cb_ad_oe_i, cb_cbe_oe_i, cb_irdy_oe_i, cb_perr_oe_i, cb_par_oe_i} = '1;
		for (int i = 0; i < 32; i++) begin
			v = 32'h1 << i;
			cb_ad_i = v;
			{cb_gnt_n_i, cb_irdy_n_i, cb_perr_n_i, cb_par_i, cb_cbe_n_i} = {i[1:0], i[4:0]};
			step(1);
			check(sock_d_o[15], v[8]);
			check(sock_d_oe_o[14] | sock_d_oe_o[2], 1'b0);
			check(sock_d_o[13:3], {v[6], v[4], v[2], v[31], v[30], v[28], v[7], v[5], v[3], v[1], v[0]});
			check(sock_d_o[1:0], {v[29], v[27]});
			check(sock_a_o[11:9], {v[12], v[9], v[14]});
			check(sock_a_o[7:0], {v[18], v[20], v[21], v[22], v[23], v[24], v[25], v[26]});
			check(sock_oe_n_o, v[11]);
			check({sock_a_o[15:12], sock_a_o[8]}, {cb_irdy_n_i, cb_perr_n_i, cb_par_i, cb_cbe_n_i[2:1]});
			check(sock_we_n_o, cb_gnt_n_i);
		end
		cb_ad_oe_i = 32'h0;
		card_data = 16'h96c3;
		step(2);
		check({cb_ad_o[8], cb_ad_o[29], cb_ad_o[27]}, {card_data[15], card_data[1:0]});
		check({cb_cbe_n_o, cb_irdy_n_o, cb_perr_n_o, cb_par_o}, 6'h3f);
		check(sock_we_n_oe_o, 1'b1);
		mode_cb_i = 1'b0;
		drive_en_i = 1'b1;
		addr_i = 16'h1234;
		step(1);
		check({sock_a_o, sock_a_oe_o}, 32'h1234ffff);
	endtask
	initial begin
		step(4);
		check(cb_cbe_n_o, 3'h7);
		rst_n_i = 1'b1;
		t_read;
		t_write;
		t_cardbus;
		complete_run;
	end
	initial begin
		#20000;
		miscompares++;
		complete_run;
	end
endmodule
